// File: core/spi_hold_map.svh
// Purpose: Constants of the serial slave front end with suspend.
// Assumes: Included by bare name from the package and spi_hold_slave.
// Notes: Values only; no logic here.
`ifndef SPI_HOLD_MAP_SVH
`define SPI_HOLD_MAP_SVH

// Byte framing
`define BYTE_BITS 8
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_FIRST 3'h0
`define IDLE_FILL_BYTE 8'hFF
`define IDLE_FILL_TAIL 7'h7F

// Array sizes of the two variants
`define ARRAY_DEPTH_SMALL 16384
`define ARRAY_DEPTH_LARGE 32768

// Receive buffer depth
`define RX_FIFO_DEPTH 4

// Reset values
`define SO_RESET 1'b1
`define TGL_RESET 1'b0

`endif

// File: core/spi_hold_pkg.sv
// Purpose: Types shared by the serial slave front end.
// Assumes: spi_hold_map.svh holds the numbers.
// Notes: Structs carry signals that travel together.
`default_nettype none
`include "spi_hold_map.svh"

package spi_hold_pkg;

    // Serial pins seen by the device
    typedef struct packed {
        logic select_n;
        logic suspend_n;
        logic serial_in;
    } serial_pins_t;

    // Link state as seen from the system clock
    typedef struct packed {
        logic frame_active;
        logic paused;
        logic rx_overrun;
    } link_status_t;

    // Receive capture stage
    typedef enum logic {CAP_IDLE, CAP_HOLD} cap_state_t;

endpackage : spi_hold_pkg

`default_nettype wire

// File: core/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-low reset.
// Notes: DEPTH need not be a power of two.
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] in_data, // Word to store
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    output logic [WIDTH-1:0] out_data, // Oldest word
    output logic out_valid, // Oldest word present
    input wire logic out_ready // Consumer takes the word
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [IW-1:0] wr_idx_reg, wr_idx_next, rd_idx_reg, rd_idx_next;
    logic [CW-1:0] count_reg, count_next;
    logic push, pop;

    // Index wrap at DEPTH
    function automatic logic [IW-1:0] bump(input logic [IW-1:0] idx);
        bump = (idx == IW'(DEPTH - 1)) ? '0 : IW'(idx + 1'b1);
    endfunction : bump

    ////////////////////////////////////////////////////////////////////////
    // Handshake flags from the fill count
    assign in_ready = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_idx_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next storage and pointers
    always_comb begin
        mem_next = mem_reg;
        wr_idx_next = wr_idx_reg;
        rd_idx_next = rd_idx_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_idx_reg] = in_data;
            wr_idx_next = bump(wr_idx_reg);
        end
        if (pop) begin
            rd_idx_next = bump(rd_idx_reg);
        end
        if (push && !pop) begin
            count_next = CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_next = CW'(count_reg - 1'b1);
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            wr_idx_reg <= wr_idx_next;
            rd_idx_reg <= rd_idx_next;
            count_reg <= count_next;
            mem_reg <= mem_next;
        end
    end

endmodule : byte_fifo

`default_nettype wire

// File: core/spi_hold_slave.sv
// Purpose: Serial slave front end: bit clocking, byte framing, suspend.
// Assumes: Mode 0 master; serial clock stops outside frames.
// Notes: Link logic runs on sclk; bytes cross to clk by toggles.
`default_nettype none
`include "spi_hold_map.svh"

module spi_hold_slave
    import spi_hold_pkg::*;
#(
    parameter int ARRAY_DEPTH = `ARRAY_DEPTH_LARGE,
    parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst_n, // Reset, active low; synchronous on clk, asynchronous on the link toggle flops
    input wire logic sclk, // Serial clock from the master
    input wire serial_pins_t pins, // Select, suspend and serial input
    output logic serial_out, // Serial output level
    output logic serial_out_oe, // Serial output enable, high drives
    output logic [7:0] rx_data, // Received byte
    output logic rx_valid, // Received byte present
    input wire logic rx_ready, // Consumer takes received byte
    input wire logic [7:0] tx_data, // Byte to send
    input wire logic tx_valid, // Byte to send offered
    output logic tx_ready, // Send slot free
    input wire logic overrun_clr, // Clears the overrun flag
    output link_status_t status // Frame, pause and overrun state
);
    localparam int ADDR_BITS = $clog2(ARRAY_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Link domain, rising edge: shift in, framing
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [6:0] rx_shift_reg, rx_shift_next;
    logic frame_live_reg, frame_live_next;
    logic [7:0] rx_hold_reg, rx_hold_next;
    logic rx_tgl_reg, rx_tgl_next;
    logic link_run;

    // Suspend gates every serial clock edge of the shift, framing and load logic
    assign link_run = pins.suspend_n;

    // Bit counter and input shifter
    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        rx_shift_next = rx_shift_reg;
        frame_live_next = frame_live_reg;
        if (link_run) begin
            rx_shift_next = {rx_shift_reg[5:0], pins.serial_in};
            bit_cnt_next = 3'(bit_cnt_reg + 1'b1);
            frame_live_next = 1'b1;
        end
    end

    // Deselect clears partial state at once
    always_ff @(posedge sclk or posedge pins.select_n) begin
        if (pins.select_n) begin
            bit_cnt_reg <= `BIT_CNT_FIRST;
            rx_shift_reg <= '0;
            frame_live_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            rx_shift_reg <= rx_shift_next;
            frame_live_reg <= frame_live_next;
        end
    end

    // Whole byte handed to the system side
    always_comb begin
        rx_hold_next = rx_hold_reg;
        rx_tgl_next = rx_tgl_reg;
        if (link_run && frame_live_next && bit_cnt_reg == `BIT_CNT_LAST) begin
            rx_hold_next = {rx_shift_reg, pins.serial_in};
            rx_tgl_next = ~rx_tgl_reg;
        end
    end

    // Byte hand-over survives deselect
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold_reg <= '0;
            rx_tgl_reg <= `TGL_RESET;
        end else begin
            rx_hold_reg <= rx_hold_next;
            rx_tgl_reg <= rx_tgl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain, falling edge: shift out
    logic so_reg, so_next;
    logic [6:0] tx_shift_reg, tx_shift_next;
    logic out_en_reg, out_en_next;
    logic req_meta_reg, req_sync_reg, ack_reg, ack_next;
    logic tx_req_reg;
    logic [7:0] tx_word_reg;
    logic load_slot, load_take;

    // Byte boundary reached, new byte may start
    assign load_slot = link_run && frame_live_reg && (bit_cnt_reg == `BIT_CNT_FIRST);
    assign load_take = load_slot && (req_sync_reg != ack_reg);

    // Output shifter, idle fill when nothing offered
    always_comb begin
        so_next = so_reg;
        tx_shift_next = tx_shift_reg;
        out_en_next = out_en_reg;
        if (load_slot) begin
            so_next = load_take ? tx_word_reg[7] : 1'b1;
            tx_shift_next = load_take ? tx_word_reg[6:0] : `IDLE_FILL_TAIL;
            out_en_next = out_en_reg | load_take;
        end else if (link_run && frame_live_reg) begin
            so_next = tx_shift_reg[6];
            tx_shift_next = {tx_shift_reg[5:0], 1'b1};
        end
    end

    // Output state drops on deselect
    always_ff @(negedge sclk or posedge pins.select_n) begin
        if (pins.select_n) begin
            so_reg <= `SO_RESET;
            tx_shift_reg <= `IDLE_FILL_TAIL;
            out_en_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
            tx_shift_reg <= tx_shift_next;
            out_en_reg <= out_en_next;
        end
    end

    // Send request sync and acknowledge toggle
    assign ack_next = ack_reg ^ load_take;

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            req_meta_reg <= `TGL_RESET;
            req_sync_reg <= `TGL_RESET;
            ack_reg <= `TGL_RESET;
        end else begin
            req_meta_reg <= tx_req_reg;
            req_sync_reg <= req_meta_reg;
            ack_reg <= ack_next;
        end
    end

    // Pin driven only while selected, running and sending
    assign serial_out = so_reg;
    assign serial_out_oe = ~pins.select_n & pins.suspend_n & out_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers
    logic sel_meta_reg, sel_sync_reg, sus_meta_reg, sus_sync_reg;
    logic rxt_meta_reg, rxt_sync_reg, ack_meta_reg, ack_sync_reg;

    // Two flops on every crossing level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_meta_reg <= 1'b1;
            sel_sync_reg <= 1'b1;
            sus_meta_reg <= 1'b1;
            sus_sync_reg <= 1'b1;
            rxt_meta_reg <= `TGL_RESET;
            rxt_sync_reg <= `TGL_RESET;
            ack_meta_reg <= `TGL_RESET;
            ack_sync_reg <= `TGL_RESET;
        end else begin
            sel_meta_reg <= pins.select_n;
            sel_sync_reg <= sel_meta_reg;
            sus_meta_reg <= pins.suspend_n;
            sus_sync_reg <= sus_meta_reg;
            rxt_meta_reg <= rx_tgl_reg;
            rxt_sync_reg <= rxt_meta_reg;
            ack_meta_reg <= ack_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: receive capture, send slot, status
    cap_state_t cap_state_reg, cap_state_next;
    logic rxt_seen_reg, rxt_seen_next;
    logic [7:0] cap_byte_reg, cap_byte_next;
    logic overrun_reg, overrun_next;
    logic tx_req_next;
    logic [7:0] tx_word_next;
    logic fifo_in_ready, rx_new;
    link_status_t status_next;

    assign rx_new = (rxt_sync_reg != rxt_seen_reg);
    assign tx_ready = (tx_req_reg == ack_sync_reg);

    // Capture, hand to buffer, track overrun and send slot
    always_comb begin
        cap_state_next = cap_state_reg;
        rxt_seen_next = rxt_seen_reg;
        cap_byte_next = cap_byte_reg;
        overrun_next = overrun_reg & ~overrun_clr;
        tx_req_next = tx_req_reg;
        tx_word_next = tx_word_reg;
        case (cap_state_reg)
            CAP_IDLE: begin
                if (rx_new) begin
                    cap_byte_next = rx_hold_reg;
                    rxt_seen_next = rxt_sync_reg;
                    cap_state_next = CAP_HOLD;
                end
            end
            CAP_HOLD: begin
                if (fifo_in_ready) begin
                    cap_state_next = CAP_IDLE;
                end else if (rx_new) begin
                    overrun_next = 1'b1;
                    // Newer byte replaces the stalled one; the event is taken once
                    cap_byte_next = rx_hold_reg;
                    rxt_seen_next = rxt_sync_reg;
                end
            end
            default: begin
                cap_state_next = CAP_IDLE;
            end
        endcase
        if (tx_valid && tx_ready) begin
            tx_word_next = tx_data;
            tx_req_next = ~tx_req_reg;
        end
        status_next.frame_active = ~sel_sync_reg;
        status_next.paused = ~sel_sync_reg & ~sus_sync_reg;
        status_next.rx_overrun = overrun_reg;
    end

    // Register stage of the system side
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_state_reg <= CAP_IDLE;
            rxt_seen_reg <= `TGL_RESET;
            cap_byte_reg <= '0;
            overrun_reg <= 1'b0;
            tx_req_reg <= `TGL_RESET;
            tx_word_reg <= `IDLE_FILL_BYTE;
            status <= '0;
        end else begin
            cap_state_reg <= cap_state_next;
            rxt_seen_reg <= rxt_seen_next;
            cap_byte_reg <= cap_byte_next;
            overrun_reg <= overrun_next;
            tx_req_reg <= tx_req_next;
            tx_word_reg <= tx_word_next;
            status <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer
    byte_fifo #(
        .WIDTH(`BYTE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(cap_byte_reg),
        .in_valid(cap_state_reg == CAP_HOLD),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

endmodule : spi_hold_slave

`default_nettype wire

// File: dv/spi_hold_properties.sv
// Purpose: Concurrent checks on the serial slave ports.
// Assumes: Bound to spi_hold_slave; mode 0 master.
// Notes: Status checks allow for the sync lag of three cycles.
`default_nettype none

module spi_hold_props
    import spi_hold_pkg::*;
#(
    parameter int ARRAY_DEPTH = 32768,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic sclk, // Serial clock
    input wire serial_pins_t pins, // Serial pins
    input wire logic serial_out, // Serial output level
    input wire logic serial_out_oe, // Serial output enable
    input wire logic [7:0] rx_data, // Received byte
    input wire logic rx_valid, // Received byte present
    input wire logic rx_ready, // Consumer ready
    input wire logic [7:0] tx_data, // Byte to send
    input wire logic tx_valid, // Send offered
    input wire logic tx_ready, // Send slot free
    input wire logic overrun_clr, // Overrun clear
    input wire link_status_t status // Link status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic so_at_rise;

    ////////////////////////////////////////////////////////////////
    // Output level seen at each rising serial edge
    always_ff @(posedge sclk) begin
        so_at_rise <= serial_out;
    end

    ////////////////////////////////////////////////////////////////
    a_oe_deselect_off: assert property (
        @(posedge clk) disable iff (!rst_n) pins.select_n |-> !serial_out_oe)
        else $error("output enabled while deselected");
    a_oe_paused_off: assert property (
        @(posedge clk) disable iff (!rst_n) !pins.suspend_n |-> !serial_out_oe)
        else $error("output enabled while paused");
    a_out_falls_only: assert property (
        @(negedge sclk) disable iff (!rst_n || pins.select_n) serial_out == so_at_rise)
        else $error("output changed between rise and fall");
    a_tx_slot_taken: assert property (
        @(posedge clk) disable iff (!rst_n) tx_valid && tx_ready |=> !tx_ready)
        else $error("send slot still free after take");
    a_rx_word_holds: assert property (
        @(posedge clk) disable iff (!rst_n) rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte changed before pop");
    a_frame_seen: assert property (
        @(posedge clk) disable iff (!rst_n) (!pins.select_n) [*5] |-> status.frame_active)
        else $error("frame not reported");
    a_pause_seen: assert property (
        @(posedge clk) disable iff (!rst_n) (!pins.select_n && !pins.suspend_n) [*5] |-> status.paused)
        else $error("pause not reported");
    a_deselect_release: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(pins.select_n) |-> !serial_out_oe && serial_out)
        else $error("output not released at deselect");
endmodule : spi_hold_props

`default_nettype wire

// File: dv/spi_master_model.sv
// Purpose: Mode 0 bus master driving the serial slave.
// Assumes: Serial clock of 80 ns, still outside frames.
// Notes: A released data line shows the inverse of its last level.
`default_nettype none

module spi_master_model
    import spi_hold_pkg::*;
(
    output var logic sclk, // Serial clock, idle low
    output var serial_pins_t pins, // Select, suspend, data in
    input wire logic serial_out, // Device data level
    input wire logic serial_out_oe // Device drives data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_so;
    logic so_wire;

    // Remember the last driven level of the data line
    always @(serial_out or serial_out_oe) begin
        if (serial_out_oe) begin
            last_so = serial_out;
        end
    end
    assign so_wire = serial_out_oe ? serial_out : ~last_so;

    initial begin
        sclk = 1'b0;
        pins = 3'h2;
        last_so = 1'b1;
        // One deselect edge so the link flops start cleared
        #1;
        pins.select_n = 1'b1;
    end

    // Select with the clock low; first bit goes on the first rise
    task automatic frame_begin();
        #7;
        pins.select_n = 1'b0;
        #80;
    endtask : frame_begin

    // Deselect; a pending pause ends with it
    task automatic frame_end();
        #80;
        pins.select_n = 1'b1;
        pins.suspend_n = 1'b1;
        #120;
    endtask : frame_end

    // Shift n bits MSB first, sampling device data on each rise
    task automatic shift_bits(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < n; i++) begin
            pins.serial_in = d[7 - i];
            #40;
            sclk = 1'b1;
            q = {q[6:0], so_wire};
            #40;
            sclk = 1'b0;
        end
    endtask : shift_bits

    // Move suspend only while the clock is low
    task automatic hold_set(input logic v);
        #20;
        pins.suspend_n = v;
        #20;
    endtask : hold_set

    // Clock edges and data noise that a paused device ignores
    task automatic toggle(input int n);
        repeat (n) begin
            pins.serial_in = ~pins.serial_in;
            #40;
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
    endtask : toggle
endmodule : spi_master_model

`default_nettype wire

// File: dv/spi_eeprom_hold_clocking_tb.sv
// Purpose: Self-checking bench of the serial slave with suspend.
// Assumes: Master model drives the link; bench drives the user side.
// Notes: User-side inputs change on the falling system clock edge.
`default_nettype none

module spi_eeprom_hold_clocking_tb
    import spi_hold_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, sclk, serial_out, serial_out_oe, rx_valid, rx_ready, tx_valid, tx_ready, overrun_clr;
    logic [7:0] rx_data, tx_data, q;
    serial_pins_t pins;
    link_status_t status;
    int n_mismatch = 0;
    int tests_run = 0;

    spi_hold_slave u_spi_hold_slave (.clk(clk), .rst_n(rst_n), .sclk(sclk), .pins(pins),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .overrun_clr(overrun_clr), .status(status));
    spi_master_model u_spi_master_model (.sclk(sclk), .pins(pins), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe));

    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Wait for a byte, compare, pop it
    task automatic pop_expect(input logic [7:0] exp);
        int t;
        t = 0;
        while (rx_valid !== 1'b1 && t < 40) begin
            @(negedge clk);
            t++;
        end
        check("rx_data", exp, rx_valid === 1'b1 ? rx_data : ~exp);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
        @(negedge clk);
    endtask : pop_expect

    ////////////////////////////////////////////////////////////////
    task automatic t_receive();
        u_spi_master_model.frame_begin();
        u_spi_master_model.shift_bits(8'hA5, 8, q);
        u_spi_master_model.shift_bits(8'h3C, 8, q);
        check("frame_active", 8'h01, {7'h00, status.frame_active});
        u_spi_master_model.frame_end();
        @(negedge clk);
        pop_expect(8'hA5);
        pop_expect(8'h3C);
    endtask : t_receive

    task automatic t_transmit();
        @(negedge clk);
        tx_data = 8'h96;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
        check("tx_ready", 8'h00, {7'h00, tx_ready});
        u_spi_master_model.frame_begin();
        u_spi_master_model.shift_bits(8'h00, 8, q);
        u_spi_master_model.shift_bits(8'h55, 8, q);
        check("serial_out byte", 8'h96, q);
        u_spi_master_model.frame_end();
        @(negedge clk);
        check("tx_ready back", 8'h01, {7'h00, tx_ready});
        pop_expect(8'h00);
        pop_expect(8'h55);
    endtask : t_transmit

    task automatic t_suspend();
        u_spi_master_model.frame_begin();
        u_spi_master_model.shift_bits(8'hC3, 4, q);
        u_spi_master_model.hold_set(1'b0);
        u_spi_master_model.toggle(3);
        check("paused", 8'h01, {7'h00, status.paused});
        check("oe paused", 8'h00, {7'h00, serial_out_oe});
        u_spi_master_model.hold_set(1'b1);
        u_spi_master_model.shift_bits(8'h30, 4, q);
        u_spi_master_model.frame_end();
        @(negedge clk);
        pop_expect(8'hC3);
    endtask : t_suspend

    task automatic t_abort();
        u_spi_master_model.frame_begin();
        u_spi_master_model.shift_bits(8'hF0, 5, q);
        u_spi_master_model.hold_set(1'b0);
        u_spi_master_model.frame_end();
        check("oe abort", 8'h00, {7'h00, serial_out_oe});
        u_spi_master_model.frame_begin();
        u_spi_master_model.shift_bits(8'h5A, 8, q);
        u_spi_master_model.frame_end();
        @(negedge clk);
        pop_expect(8'h5A);
        repeat (8) @(negedge clk);
        check("rx empty", 8'h00, {7'h00, rx_valid});
    endtask : t_abort

    // Fill past the buffer while the consumer stalls
    task automatic t_overrun();
        u_spi_master_model.frame_begin();
        for (int i = 0; i < 6; i++) begin
            u_spi_master_model.shift_bits({4'h1, 4'(i)}, 8, q);
        end
        u_spi_master_model.frame_end();
        @(negedge clk);
        check("overrun", 8'h01, {7'h00, status.rx_overrun});
        overrun_clr = 1'b1;
        @(negedge clk);
        overrun_clr = 1'b0;
        repeat (2) @(negedge clk);
        check("overrun clear", 8'h00, {7'h00, status.rx_overrun});
        for (int i = 0; i < 4; i++) begin
            pop_expect({4'h1, 4'(i)});
        end
        pop_expect(8'h15);
        rx_ready = 1'b1;
        repeat (12) @(negedge clk);
        rx_ready = 1'b0;
        check("drained", 8'h00, {7'h00, rx_valid});
    endtask : t_overrun

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #100us;
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst_n = 1'b1;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        overrun_clr = 1'b0;
        // Falling reset edge also clears the link toggle flops
        #1;
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_receive();
        t_transmit();
        t_suspend();
        t_abort();
        t_overrun();
        finish_test();
    end
endmodule : spi_eeprom_hold_clocking_tb

bind spi_hold_slave spi_hold_props #(.ARRAY_DEPTH(ARRAY_DEPTH), .FIFO_DEPTH(FIFO_DEPTH)) u_spi_hold_props (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .pins(pins), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .overrun_clr(overrun_clr), .status(status));

`default_nettype wire
